/* File: design/register_space_access_decode.v */
`include "reg_space_regs.vh"
`default_nettype none

// shift-register fifo: the head entry is a flip-flop, so outputs are registered
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4
) (
  input  wire             mclk,
  input  wire             nrst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1]; // entry 0 is the head
  reg  [DEPTH-1:0] vld;             // per-entry occupancy
  reg  [7:0]       cnt;             // number of stored words
  wire             push;
  wire             pop;
  wire [7:0]       next_cnt;

  assign in_ready  = (cnt != DEPTH[7:0]);
  assign push      = in_valid & in_ready;
  assign pop       = vld[0] & out_ready;
  assign next_cnt  = cnt + {7'h00, push} - {7'h00, pop};
  assign out_data  = mem[0];
  assign out_valid = vld[0];

  // occupancy count
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      cnt <= 8'h00;
    else
      cnt <= next_cnt;
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      // each entry below the last shifts forward on pop, or catches the pushed word
      always @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          mem[i] <= {WIDTH{1'b0}};
          vld[i] <= 1'b0;
        end
        else
        begin
          vld[i] <= (i < next_cnt);
          if (pop)
          begin
            if (push && (i == cnt - 1))
              mem[i] <= in_data;
            else if (i < DEPTH - 1)
              mem[i] <= mem[(i < DEPTH - 1) ? i + 1 : i];
          end
          else if (push && (i == cnt))
            mem[i] <= in_data;
        end
      end
    end
  endgenerate
endmodule

// Operation
// - data port ignores two low address bits
// - data port bytes accepted in any address order
// - window accepts one byte up to maximum
// - longer window transfers paced by burst allowance
// - window and port stream at fixed offset
// - fifo interface identifier register is implemented
// - long read returns start register first
// - long write updates starting register, neighbours optional
// - dropped neighbour bytes leave neighbour unchanged
// - boundary-crossing transfers complete, never abort
// - no leftover bytes leak into next transfer
// - other registers (not port or window) decoded exactly per byte
// - multi-byte registers little endian, ascending
// - oversize aligned write touches only start register while CTRL_ADJ_WR_BIT is clear
// - oversize aligned read returns start register data
// - window optional where bus lacks size limit
// - locality windows mirror one shared register set
module register_space_access_decode (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       link_sck,
  input  wire       link_cs_n,
  input  wire       link_mosi,
  output reg        link_miso,
  output reg        link_miso_oe,
  output wire [7:0] cmd_data,
  output wire       cmd_valid,
  input  wire       cmd_ready,
  input  wire [7:0] rsp_data,
  input  wire       rsp_valid,
  output reg        rsp_ready
);
  // frame states
  localparam ST_CMD  = 4'b0001; // command byte
  localparam ST_AHI  = 4'b0010; // address high byte
  localparam ST_ALO  = 4'b0100; // address low byte
  localparam ST_DATA = 4'b1000; // data bytes until chip select rises

  // synchronisers: stage 1 feeds stage 2 only
  reg        sck_s1;
  reg        sck_s2;
  reg        sck_s3;    // delayed copy for edge detection
  reg        cs_n_s1;
  reg        cs_n_s2;
  reg        cs_n_s3;
  reg        mosi_s1;
  reg        mosi_s2;

  reg  [3:0]  state;
  reg  [2:0]  bit_cnt;  // bits received in current byte
  reg  [7:0]  rx_sh;    // incoming shift register
  reg  [7:0]  tx_sh;    // outgoing shift register
  reg         is_read;  // direction of current frame
  reg  [7:0]  addr_hi;
  reg  [11:0] ptr;      // byte address within the locality window
  reg  [2:0]  start_id; // register addressed by the start address
  reg  [31:0] ctrl;     // software control register
  reg         overrun;  // sticky: port or window byte lost on full fifo

  wire        sck_rise;
  wire        sck_fall;
  wire        frame_go;
  wire        frame_on;
  wire        byte_done;
  wire [7:0]  rx_byte;
  wire        fifo_in_ready;
  reg         fifo_push;
  reg  [7:0]  fifo_wdata;
  wire [15:0] burst;
  wire [31:0] sts_word;
  wire [2:0]  cur_id;
  wire        wr_allowed;
  wire        cur_stream;
  wire [11:0] adv_ptr;

  assign sck_rise  = sck_s2 & ~sck_s3;
  assign sck_fall  = ~sck_s2 & sck_s3;
  assign frame_go  = ~cs_n_s2 & cs_n_s3;
  assign frame_on  = ~cs_n_s2;
  assign byte_done = frame_on & sck_rise & (bit_cnt == 3'h7);
  assign rx_byte   = {rx_sh[6:0], mosi_s2};

  // exact byte decode; only the data port and the window ignore their two low bits
  function [2:0] reg_of;
    input [11:0] a;
    begin
      if (a[11:2] == `OFS_DATA >> 2)
        reg_of = `ID_DATA;
      else if (a[11:2] == `OFS_XDATA >> 2)
        reg_of = `ID_XDATA;
      else if (a[11:2] == `OFS_CTRL >> 2)
        reg_of = `ID_CTRL;
      else if (a[11:2] == `OFS_CAP >> 2)
        reg_of = `ID_CAP;
      else if (a[11:2] == `OFS_STS >> 2)
        reg_of = `ID_STS;
      else if (a[11:2] == `OFS_IDENT >> 2)
        reg_of = `ID_IDENT;
      else
        reg_of = `ID_NONE;
    end
  endfunction

  // lane select: lowest address carries bits 7:0
  function [7:0] lane_of;
    input [31:0] w;
    input [1:0]  l;
    begin
      case (l)
        2'h0:    lane_of = w[7:0];
        2'h1:    lane_of = w[15:8];
        2'h2:    lane_of = w[23:16];
        default: lane_of = w[31:24];
      endcase
    end
  endfunction

  // burst reads one while the fifo has a free slot, zero when it is full
  assign burst      = fifo_in_ready ? 16'h0001 : 16'h0000;
  assign sts_word   = ({16'h0000, burst} << `STS_BURST_LSB)
                    | ({31'h0, fifo_in_ready} << `STS_EXPECT_BIT)
                    | ({31'h0, overrun} << `STS_OVERRUN_BIT);

  assign cur_id     = reg_of(ptr);
  assign cur_stream = (cur_id == `ID_DATA) | (cur_id == `ID_XDATA);
  // neighbours written only when software opted in
  assign wr_allowed = (cur_id == start_id) | ctrl[`CTRL_ADJ_WR_BIT];
  // streaming registers hold the address across bytes
  assign adv_ptr    = cur_stream ? ptr : ptr + 12'h001;

  // two-flop synchronisers for every link input pin
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      sck_s3  <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      cs_n_s3 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end
    else
    begin
      sck_s1  <= link_sck;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      cs_n_s1 <= link_cs_n;
      cs_n_s2 <= cs_n_s1;
      cs_n_s3 <= cs_n_s2;
      mosi_s1 <= link_mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  // byte fetch for reads: start register first, then neighbour or filler
  function [7:0] read_byte;
    input [11:0] a;
    input [2:0]  sid;
    input [31:0] c;
    input [31:0] s;
    input [7:0]  rsp;
    input        rsp_ok;
    reg   [2:0]  id;
    begin
      id = reg_of(a);
      if ((id != sid) && !c[`CTRL_ADJ_RD_BIT])
        read_byte = `FILL_BYTE;
      else
        case (id)
          `ID_CTRL:  read_byte = lane_of(c, a[1:0]);
          `ID_CAP:   read_byte = lane_of(`CAP_RESET
                       | ({30'h0, `CAP_SIZE_VALUE} << `CAP_SIZE_LSB), a[1:0]);
          `ID_STS:   read_byte = lane_of(s, a[1:0]);
          `ID_IDENT: read_byte = lane_of(`IDENT_VALUE, a[1:0]);
          `ID_DATA,
          `ID_XDATA: read_byte = rsp_ok ? rsp : `FILL_BYTE;
          default:   read_byte = `FILL_BYTE;
        endcase
    end
  endfunction

  // frame sequencer, decode and register writes
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state        <= ST_CMD;
      bit_cnt      <= 3'h0;
      rx_sh        <= 8'h00;
      tx_sh        <= 8'h00;
      is_read      <= 1'b0;
      addr_hi      <= 8'h00;
      ptr          <= 12'h000;
      start_id     <= `ID_NONE;
      ctrl         <= `CTRL_RESET;
      overrun      <= 1'b0;
      fifo_push    <= 1'b0;
      fifo_wdata   <= 8'h00;
      rsp_ready    <= 1'b0;
      link_miso    <= 1'b0;
      link_miso_oe <= 1'b0;
    end
    else
    begin
      fifo_push    <= 1'b0;
      rsp_ready    <= 1'b0;
      link_miso_oe <= frame_on;
      if (frame_go)
      begin
        // fresh frame: drop every partial byte of the last one
        state   <= ST_CMD;
        bit_cnt <= 3'h0;
        rx_sh   <= 8'h00;
        tx_sh   <= 8'h00;
        is_read <= 1'b0;
      end
      else if (frame_on)
      begin
        // shift out on falling edges, msb first
        if (sck_fall)
        begin
          link_miso <= tx_sh[7];
          tx_sh     <= {tx_sh[6:0], 1'b0};
        end
        if (sck_rise)
        begin
          rx_sh   <= rx_byte;
          bit_cnt <= bit_cnt + 3'h1;
        end
        if (byte_done)
        begin
          case (state)
            ST_CMD:
            begin
              is_read <= rx_byte[`CMD_READ_BIT];
              state   <= ST_AHI;
            end
            ST_AHI:
            begin
              // locality nibble dropped: all windows share one register set
              addr_hi <= rx_byte;
              state   <= ST_ALO;
            end
            ST_ALO:
            begin
              ptr      <= {addr_hi[3:0], rx_byte};
              start_id <= reg_of({addr_hi[3:0], rx_byte});
              state    <= ST_DATA;
              if (is_read)
              begin
                tx_sh <= read_byte({addr_hi[3:0], rx_byte},
                                   reg_of({addr_hi[3:0], rx_byte}),
                                   ctrl, sts_word, rsp_data, rsp_valid);
                if (rsp_valid && ((reg_of({addr_hi[3:0], rx_byte}) == `ID_DATA)
                    || (reg_of({addr_hi[3:0], rx_byte}) == `ID_XDATA)))
                  rsp_ready <= 1'b1;
              end
            end
            ST_DATA:
            begin
              // any length is taken; nothing aborts the transfer
              ptr <= adv_ptr;
              if (is_read)
              begin
                tx_sh <= read_byte(adv_ptr, start_id, ctrl, sts_word,
                                   rsp_data, rsp_valid);
                if (rsp_valid && cur_stream
                    && ((cur_id == start_id) || ctrl[`CTRL_ADJ_RD_BIT]))
                  rsp_ready <= 1'b1;
              end
              else if (wr_allowed)
              begin
                case (cur_id)
                  `ID_DATA,
                  `ID_XDATA:
                  begin
                    // any byte lane, any order, one byte stream
                    if (fifo_in_ready)
                    begin
                      fifo_push  <= 1'b1;
                      fifo_wdata <= rx_byte;
                    end
                  end
                  `ID_CTRL:
                  begin
                    case (ptr[1:0])
                      2'h0:    ctrl[7:0]   <= rx_byte;
                      2'h1:    ctrl[15:8]  <= rx_byte;
                      2'h2:    ctrl[23:16] <= rx_byte;
                      default: ctrl[31:24] <= rx_byte;
                    endcase
                  end
                  default:
                  begin
                    // read-only registers ignore writes
                  end
                endcase
              end
            end
            default:
              state <= ST_CMD;
          endcase
        end
      end
      // sticky overrun; a new loss wins over a write-one clear
      if (byte_done && (state == ST_DATA) && !is_read && wr_allowed
          && cur_stream && !fifo_in_ready)
        overrun <= 1'b1;
      else if (byte_done && (state == ST_DATA) && !is_read && wr_allowed
               && (cur_id == `ID_STS) && (ptr[1:0] == 2'h0)
               && rx_byte[`STS_OVERRUN_BIT])
        overrun <= 1'b0;
    end
  end

  // the fifo stands between the link and the command consumer
  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_data   (fifo_wdata),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (cmd_data),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready)
  );

endmodule

`default_nettype wire

/* File: inc/reg_space_regs.vh */
`ifndef REG_SPACE_REGS_VH
`define REG_SPACE_REGS_VH

// byte offsets inside one locality window (upper address nibble is the locality)
`define OFS_CTRL        12'h008
`define OFS_CAP         12'h014
`define OFS_STS         12'h018
`define OFS_DATA        12'h024
`define OFS_IDENT       12'h030
`define OFS_CRB_IDENT   12'h034
`define OFS_XDATA       12'h080

// register identities used by the decoder
`define ID_NONE         3'h0
`define ID_CTRL         3'h1
`define ID_CAP          3'h2
`define ID_STS          3'h3
`define ID_DATA         3'h4
`define ID_IDENT        3'h5
`define ID_XDATA        3'h6

// link command byte: bit 7 set means read
`define CMD_READ_BIT    7

// control register fields and reset value
`define CTRL_ADJ_WR_BIT 0
`define CTRL_ADJ_RD_BIT 1
`define CTRL_RESET      32'h0000_0000

// status register fields
`define STS_OVERRUN_BIT 0
`define STS_EXPECT_BIT  3
`define STS_BURST_LSB   8

// capability: max transfer size field sits in bits 10:9
`define CAP_SIZE_LSB    9
`define CAP_SIZE_VALUE  2'h0
`define CAP_RESET       32'h0000_0000

// identifier value is arbitrary
`define IDENT_VALUE     32'h0000_5A11

// filler byte for unbacked read bytes
`define FILL_BYTE       8'hFF

// fifo shape
`define FIFO_WIDTH      8
`define FIFO_DEPTH      4

`endif

/* File: verif/register_space_access_decode_properties.sv */
`default_nettype none
// pin-level watch on framing, fifo head and response handshake
module reg_space_checker (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       link_sck,
  input wire logic       link_cs_n,
  input wire logic       link_mosi,
  input wire logic       link_miso,
  input wire logic       link_miso_oe,
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // select passes a two-flop synchroniser, so allow a few cycles
  a_oe_on_select: assert property ($fell(link_cs_n) |-> ##[1:6] link_miso_oe)
    else $error("driver not enabled after select");
  a_oe_off_end: assert property ($rose(link_cs_n) |-> ##[1:6] !link_miso_oe)
    else $error("driver still on after frame");
  a_idle_released: assert property (link_cs_n [*8] |-> !link_miso_oe)
    else $error("driver on between frames");
  // a stalled head must neither vanish nor change
  a_head_stands: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
    else $error("fifo head lost while stalled");
  a_drop_on_pop: assert property ($fell(cmd_valid) |-> $past(cmd_ready))
    else $error("fifo head dropped without pop");
  a_push_in_frame: assert property ($rose(cmd_valid) |-> !$past(link_cs_n, 3) || $past(cmd_ready))
    else $error("byte pushed outside a frame");
  a_rsp_one_cycle: assert property (rsp_ready |=> !rsp_ready)
    else $error("response take longer than one cycle");
  // stale bytes must not pull responses once the frame has gone
  a_rsp_in_frame: assert property (rsp_ready |-> !$past(link_cs_n, 4))
    else $error("response taken outside a frame");
  c_fifo_full: cover property (cmd_valid && !cmd_ready [*8]);
  c_pop: cover property (cmd_valid && cmd_ready);
  c_rsp: cover property (rsp_ready);
endmodule
bind register_space_access_decode reg_space_checker u_chk (.mclk, .nrst, .link_sck, .link_cs_n,
  .link_mosi, .link_miso, .link_miso_oe, .cmd_data, .cmd_valid, .cmd_ready, .rsp_data,
  .rsp_valid, .rsp_ready);
`default_nettype wire

/* File: verif/link_host.sv */
`default_nettype none
// host on the serial link; clock runs only inside frames
module link_host (
  output var logic link_sck,
  output var logic link_cs_n,
  output var logic link_mosi,
  input wire logic miso_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wq[$];  // bytes to send, low byte first
  logic [7:0] rq[$];  // bytes seen during the data phase
  initial
  begin
    link_sck = 0;
    link_cs_n = 1;
    link_mosi = 0;
  end
  // one byte msb first: data set while low, miso taken at the rise
  task automatic shift_byte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      link_mosi = b[i];
      #80 link_sck = 1;
      r[i] = miso_line;
      #80 link_sck = 0;
    end
  endtask
  // command, address high, address low, then n data bytes in ascending order
  task automatic frame(input logic rd, input logic [15:0] a, input int n);
    logic [7:0] r;
    rq.delete();
    link_cs_n = 0;
    #80;
    shift_byte({rd, 7'h00}, r);
    shift_byte(a[15:8], r);
    shift_byte(a[7:0], r);
    for (int k = 0; k < n; k++)
    begin
      shift_byte(rd ? ~r : wq[k], r);
      rq.push_back(r);
    end
    #80 link_cs_n = 1;
    // released line must not keep the last bit
    link_mosi = ~link_mosi;
    #400;
  endtask
endmodule
`default_nettype wire

/* File: verif/register_space_access_decode_tb.sv */
`default_nettype none
module register_space_access_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, nrst, cmd_ready, rsp_valid;
  logic [7:0] rsp_data;
  wire logic  link_sck, link_cs_n, link_mosi, link_miso, link_miso_oe;
  wire logic  cmd_valid, rsp_ready, miso_line;
  wire logic [7:0] cmd_data;
  integer     seed = 86;
  int         mismatches = 0;
  int         num_checks = 0;
  int         mode = 0;       // consumer: 0 stalled, 1 ready, 2 random
  logic [7:0] exp_q[$];       // bytes the fifo must deliver
  logic [7:0] rsp_q[$];       // response bytes the device took
  logic [7:0] v;
  // pull-up holds the line when the device lets go
  assign miso_line = link_miso_oe ? link_miso : 1'b1;
  register_space_access_decode u_dut (.mclk, .nrst, .link_sck, .link_cs_n, .link_mosi,
    .link_miso, .link_miso_oe, .cmd_data, .cmd_valid, .cmd_ready, .rsp_data, .rsp_valid,
    .rsp_ready);
  link_host u_host (.link_sck, .link_cs_n, .link_mosi, .miso_line);
  initial
  begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // consumer side of the fifo and source side of responses
  always @(posedge mclk)
  begin
    cmd_ready <= (mode == 2) ? 1'($random(seed)) : (mode == 1);
    if (cmd_valid === 1'b1 && cmd_ready)
    begin
      if (exp_q.size() == 0) check8(cmd_data, 8'hxx);
      else check8(cmd_data, exp_q.pop_front());
    end
    if (rsp_ready === 1'b1)
    begin
      rsp_q.push_back(rsp_data);
      rsp_data <= 8'($random(seed));
    end
  end
  task rd_chk(input logic [15:0] a, input int n, input logic [63:0] e);
    u_host.frame(1, a, n);
    for (int k = 0; k < n; k++) check8(u_host.rq[k], e[8*k +: 8]);
  endtask
  task wr(input logic [15:0] a, input int n, input logic [63:0] d);
    u_host.wq.delete();
    for (int k = 0; k < n; k++) u_host.wq.push_back(d[8*k +: 8]);
    u_host.frame(0, a, n);
  endtask
  // reads of the data path must return the taken responses in order
  task rd_port(input logic [15:0] a, input int n);
    rsp_q.delete();
    u_host.frame(1, a, n);
    for (int k = 0; k < n; k++) check8(u_host.rq[k], rsp_q[k]);
  endtask
  // streams random bytes to one fixed offset
  task wr_stream(input logic [15:0] a, input int n);
    logic [63:0] d;
    d = {$random(seed), $random(seed)};
    for (int k = 0; k < n; k++) exp_q.push_back(d[8*k +: 8]);
    wr(a, n, d);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    nrst = 0;
    rsp_valid = 1;
    rsp_data = 8'h5C;
    repeat (5) @(posedge mclk);
    nrst <= 1;
    repeat (5) @(posedge mclk);
    rd_chk(16'h0008, 4, 64'h0);
    rd_chk(16'h0014, 4, 64'h0);
    rd_chk(16'h0030, 6, 64'hFFFF_0000_5A11);
    rd_chk(16'h3031, 1, 64'h5A);
    wr(16'h0008, 1, 64'h02);
    rd_chk(16'h0008, 1, 64'h02);
    wr(16'h0008, 1, 64'h00);
    // six single bytes on random lanes of the port, consumer stalled
    for (int k = 0; k < 6; k++)
    begin
      v = 8'($random(seed));
      if (k < 4) exp_q.push_back(v);
      wr(16'h0024 | (16'($random(seed)) & 16'h0003), 1, {56'h0, v});
    end
    rd_chk(16'h0018, 4, 64'h01);
    // oversize write from a read-only register; status bytes must drop
    wr(16'h0014, 8, 64'hFFFF_FFFF_FFFF_FFFF);
    rd_chk(16'h0018, 1, 64'h01);
    mode = 1;
    repeat (30) @(posedge mclk);
    check8(8'(exp_q.size()), 8'h00);
    rd_chk(16'h0018, 4, 64'h0109);
    wr(16'h0018, 1, 64'h01);
    rd_chk(16'h0018, 1, 64'h08);
    // neighbour reads opted in: capability then live status bytes
    wr(16'h0008, 1, 64'h02);
    rd_chk(16'h0014, 8, 64'h0000_0108_0000_0000);
    wr(16'h0008, 1, 64'h00);
    // window and port streams while the consumer stalls at random
    mode = 2;
    wr_stream(16'h0080, 1);
    wr_stream(16'h0080, 8);
    wr_stream(16'h0025, 3);
    repeat (60) @(posedge mclk);
    check8(8'(exp_q.size()), 8'h00);
    rd_port(16'h0026, 3);
    rd_port(16'h0081, 2);
    rd_chk(16'h1030, 4, 64'h5A11);
    final_report;
  end
  // about 150 bytes at 1.3 us each plus gaps; 400 us leaves ample margin
  initial
  begin
    #400000;
    mismatches++;
    final_report;
  end
endmodule
`default_nettype wire
